// ---- uart_lin_map.svh ----
// offsets, field positions, field values and counts for the host controller
`ifndef UART_LIN_MAP_SVH
`define UART_LIN_MAP_SVH

// =====================================================================
// device register addresses (16-bit registers on the device port)
`define DEV_PERIPH_EN     8'h00
`define DEV_PRESCALER     8'h02
`define DEV_PAIR_MODE     8'h04
`define DEV_RX_MODE       8'h06
`define DEV_RX_CONFIG     8'h08
`define DEV_RX_DATA       8'h0A
`define DEV_RX_STATUS     8'h0C
`define DEV_ERR_CLEAR     8'h0E
`define DEV_START_TRIG    8'h10
`define DEV_STOP_TRIG     8'h12
`define DEV_ENABLED       8'h14
`define DEV_TX_DATA       8'h16

// =====================================================================
// device field values
`define DEV_UNITS_ON      16'h0003
`define DEV_UNITS_OFF     16'h0000
`define DEV_CHAN_BITS     16'h000C
`define DEV_RX_CHAN_BIT   3
`define DEV_ERR_MASK      16'h0007
`define DEV_DIV_LSB       9
`define LIN_WAKE_BYTE     8'h00
`define LIN_BREAK_BYTE    8'h00
`define LIN_SYNC_BYTE     8'h55
`define DIV_MIN           7'h02
`define BRK_NUM           12'h00D
`define BRK_DEN           12'h009
`define PER_WAIT_CLKS     3'h4

// =====================================================================
// software register offsets
`define SW_CTRL           8'h00
`define SW_CFG_PRESCALER  8'h04
`define SW_CFG_MODE       8'h08
`define SW_CFG_PAIR       8'h0C
`define SW_CFG_COMM       8'h10
`define SW_RATE           8'h14
`define SW_TX_BYTE        8'h18
`define SW_RX_BYTE        8'h1C
`define SW_STATUS         8'h20

// software control bits
`define CTRL_START        0
`define CTRL_STOP         1
`define CTRL_LIN          2
`define CTRL_CLR_ERR      3

`endif

// ---- uart_lin_pkg.sv ----
// types shared by the host controller modules
package uart_lin_pkg;

  // controller sequence states
  typedef enum logic [4:0] {
    ST_IDLE, ST_CLK_ON, ST_CLK_WAIT, ST_PRESCALER, ST_CHECK_EN,
    ST_PAIR_MODE, ST_RX_MODE, ST_RX_CONFIG, ST_RATE, ST_CLEAR_ERR,
    ST_START, ST_RUN, ST_READ_DATA, ST_READ_ERR, ST_CLEAR_RUN,
    ST_STOP, ST_CLK_OFF, ST_WAKE, ST_WAKE_W, ST_BREAK, ST_BREAK_W,
    ST_SYNC, ST_SYNC_W, ST_DATA, ST_DATA_W
  } state_t;

  typedef logic [7:0]  dev_addr_t;
  typedef logic [15:0] dev_word_t;

endpackage

// ---- irq_sync.sv ----
// three-stage synchroniser with a one-cycle pulse on each rising level
`timescale 1ns/100ps
module irq_sync
  import uart_lin_pkg::*;
#(
  parameter int W = 3
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] s1_ff;     // first stage, read by s2 only
  logic [W-1:0] s2_ff;     // second stage
  logic [W-1:0] s3_ff;     // third stage
  logic [W-1:0] level_ff;  // accepted level
  wire  [W-1:0] agree;     // stages two and three match
  wire  [W-1:0] nxt_level;

  assign agree     = ~(s2_ff ^ s3_ff);
  assign nxt_level = (agree & s3_ff) | (~agree & level_ff);
  assign rise_o    = nxt_level & ~level_ff;

  // =====================================================================
  // shift chain and accepted level
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      level_ff <= '0;
    end
    else
    begin
      s1_ff    <= level_i;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

endmodule

// ---- dev_bus_master.sv ----
// single-access master for the device register port
`timescale 1ns/100ps
module dev_bus_master
  import uart_lin_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      req_i,      // start one access
  input  wire logic      rd_i,       // access is a read
  input  dev_addr_t      addr_i,
  input  dev_word_t      wdata_i,
  output logic           done_o,     // access finished
  output dev_word_t      rdata_o,    // read result, valid with done_o
  output dev_addr_t      dev_addr_o,
  output dev_word_t      dev_wdata_o,
  output logic           dev_we_o,
  output logic           dev_re_o,
  input  dev_word_t      dev_rdata_i
);

  logic strobe_ff;  // strobe is high this cycle
  logic rd_ff;      // last strobe was a read
  logic rcap_ff;    // device read data stands this cycle
  logic rdone_ff;   // read result captured in rdata_o

  // a write ends with its strobe; a read ends once its data is held
  assign done_o = (strobe_ff & ~rd_ff) | rdone_ff;

  // =====================================================================
  // drive one strobe per request; the device answers a read in the
  // cycle after its strobe, so the data is taken at the end of that one
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dev_addr_o  <= '0;
      dev_wdata_o <= '0;
      dev_we_o    <= 1'b0;
      dev_re_o    <= 1'b0;
      strobe_ff   <= 1'b0;
      rd_ff       <= 1'b0;
      rcap_ff     <= 1'b0;
      rdone_ff    <= 1'b0;
      rdata_o     <= '0;
    end
    else
    begin
      dev_we_o  <= req_i & ~rd_i;
      dev_re_o  <= req_i & rd_i;
      strobe_ff <= req_i;
      rcap_ff   <= strobe_ff & rd_ff;
      rdone_ff  <= rcap_ff;
      if (req_i)
      begin
        dev_addr_o  <= addr_i;
        dev_wdata_o <= wdata_i;
        rd_ff       <= rd_i;
      end
      if (rcap_ff)
        rdata_o <= dev_rdata_i;
    end
  end

endmodule

// ---- uart_lin_host.sv ----
// host controller sequencing uart reception and lin transmission
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "uart_lin_map.svh"
`timescale 1ns/100ps
module uart_lin_host
  import uart_lin_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // software port
  input  wire logic  [7:0]  sw_addr_i,
  input  wire logic  [31:0] sw_wdata_i,
  input  wire logic         sw_we_i,
  input  wire logic         sw_re_i,
  output logic       [31:0] sw_rdata_o,
  // device register port
  output dev_addr_t         dev_addr_o,
  output dev_word_t         dev_wdata_o,
  output logic              dev_we_o,
  output logic              dev_re_o,
  input  dev_word_t         dev_rdata_i,
  // device interrupt pins
  input  wire logic         rx_end_irq_i,
  input  wire logic         rx_err_irq_i,
  input  wire logic         lin_tx_irq_i
);

  // =====================================================================
  // declarations
  state_t      state_ff;        // sequence state
  state_t      nxt_state;
  logic [15:0] prescaler_ff;    // prescaler select value
  logic [15:0] mode_ff;         // receive channel mode value
  logic [15:0] pair_ff;         // paired channel mode value
  logic [15:0] comm_ff;         // communication configuration value
  logic [6:0]  div_norm_ff;     // normal rate divider
  logic [6:0]  div_wake_ff;     // wakeup rate divider
  logic [7:0]  tx_byte_ff;      // field waiting to go out
  logic        tx_pend_ff;      // field waiting
  logic [7:0]  rx_byte_ff;      // last received byte
  logic        rx_valid_ff;     // received byte not yet read
  logic        host_ovr_ff;     // byte lost on the host side
  logic [2:0]  err_ff;          // framing, parity, overrun seen
  logic        cfg_err_ff;      // refused configuration
  logic        go_ff;           // start request pending
  logic        stop_ff;         // stop request pending
  logic        lin_ff;          // frame header request pending
  logic        rx_end_ff;       // receive end interrupt pending
  logic        rx_err_ff;       // receive error interrupt pending
  logic        lin_done_ff;     // lin transmit interrupt pending
  logic [2:0]  wait_ff;         // clock enable settle counter
  logic        pend_ff;         // device access outstanding
  logic        acc;             // state makes a device access
  logic        acc_rd;          // that access is a read
  dev_addr_t   acc_addr;
  dev_word_t   acc_data;
  wire         done;            // device access finished
  dev_word_t   dev_rd;          // device read result
  wire  [2:0]  irq_rise;        // synchronised interrupt events
  wire  [6:0]  div_brk;         // sync break divider
  wire         div_bad;         // a divider below minimum
  wire         wr_ctrl;
  wire         rd_rx;

  // =====================================================================
  // helpers
  // divider for 9/13 of the rate that divider d gives
  function automatic logic [6:0] brk_divider(input logic [6:0] d);
    logic [11:0] k;
    logic [11:0] q;
    k = {5'h00, d} + 12'h001;
    q = (k * `BRK_NUM + (`BRK_DEN >> 1)) / `BRK_DEN;
    if (q > 12'h080)
      brk_divider = 7'h7F;
    else
      brk_divider = 7'(q - 12'h001);
  endfunction

  // divider word for the lin channel data register
  function automatic dev_word_t tx_word(input logic [6:0] d,
                                        input logic [7:0] b);
    tx_word = dev_word_t'({d, 9'h000}) | {8'h00, b};
  endfunction

  assign div_brk = brk_divider(div_norm_ff);
  assign div_bad = (div_norm_ff < `DIV_MIN) ||
                   (div_wake_ff < `DIV_MIN) ||
                   (div_brk < `DIV_MIN);
  assign wr_ctrl = sw_we_i && (sw_addr_i == `SW_CTRL);
  assign rd_rx   = sw_re_i && (sw_addr_i == `SW_RX_BYTE);

  // =====================================================================
  // sub-blocks
  irq_sync #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i ({lin_tx_irq_i, rx_err_irq_i, rx_end_irq_i}),
    .rise_o  (irq_rise)
  );

  dev_bus_master u_bus (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .req_i       (acc && !pend_ff),
    .rd_i        (acc_rd),
    .addr_i      (acc_addr),
    .wdata_i     (acc_data),
    .done_o      (done),
    .rdata_o     (dev_rd),
    .dev_addr_o  (dev_addr_o),
    .dev_wdata_o (dev_wdata_o),
    .dev_we_o    (dev_we_o),
    .dev_re_o    (dev_re_o),
    .dev_rdata_i (dev_rdata_i)
  );

  // =====================================================================
  // device access for each state
  always_comb
  begin
    acc      = 1'b1;
    acc_rd   = 1'b0;
    acc_addr = `DEV_PERIPH_EN;
    acc_data = `DEV_UNITS_ON;
    unique case (state_ff)
      ST_CLK_ON:    acc_data = `DEV_UNITS_ON;
      ST_PRESCALER:
      begin
        acc_addr = `DEV_PRESCALER;
        acc_data = prescaler_ff;
      end
      ST_CHECK_EN:
      begin
        acc_rd   = 1'b1;
        acc_addr = `DEV_ENABLED;
      end
      ST_PAIR_MODE:
      begin
        acc_addr = `DEV_PAIR_MODE;
        acc_data = pair_ff;
      end
      ST_RX_MODE:
      begin
        acc_addr = `DEV_RX_MODE;
        acc_data = mode_ff;
      end
      ST_RX_CONFIG:
      begin
        acc_addr = `DEV_RX_CONFIG;
        acc_data = comm_ff;
      end
      ST_RATE:
      begin
        acc_addr = `DEV_RX_DATA;
        acc_data = tx_word(div_norm_ff, 8'h00);
      end
      ST_CLEAR_ERR, ST_CLEAR_RUN:
      begin
        acc_addr = `DEV_ERR_CLEAR;
        acc_data = `DEV_ERR_MASK;
      end
      ST_START:
      begin
        acc_addr = `DEV_START_TRIG;
        acc_data = `DEV_CHAN_BITS;
      end
      ST_READ_DATA:
      begin
        acc_rd   = 1'b1;
        acc_addr = `DEV_RX_DATA;
      end
      ST_READ_ERR:
      begin
        acc_rd   = 1'b1;
        acc_addr = `DEV_RX_STATUS;
      end
      ST_STOP:
      begin
        acc_addr = `DEV_STOP_TRIG;
        acc_data = `DEV_CHAN_BITS;
      end
      ST_CLK_OFF:   acc_data = `DEV_UNITS_OFF;
      ST_WAKE:
      begin
        acc_addr = `DEV_TX_DATA;
        acc_data = tx_word(div_wake_ff, `LIN_WAKE_BYTE);
      end
      ST_BREAK:
      begin
        acc_addr = `DEV_TX_DATA;
        acc_data = tx_word(div_brk, `LIN_BREAK_BYTE);
      end
      ST_SYNC:
      begin
        acc_addr = `DEV_TX_DATA;
        acc_data = tx_word(div_norm_ff, `LIN_SYNC_BYTE);
      end
      ST_DATA:
      begin
        acc_addr = `DEV_TX_DATA;
        acc_data = tx_word(div_norm_ff, tx_byte_ff);
      end
      default:      acc = 1'b0;
    endcase
  end

  // =====================================================================
  // next state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
        if (go_ff && !div_bad)
          nxt_state = ST_CLK_ON;
      ST_CLK_ON:    if (done) nxt_state = ST_CLK_WAIT;
      ST_CLK_WAIT:
        if (wait_ff == `PER_WAIT_CLKS)
          nxt_state = ST_PRESCALER;
      ST_PRESCALER: if (done) nxt_state = ST_CHECK_EN;
      ST_CHECK_EN:
        if (done)
          nxt_state = dev_rd[`DEV_RX_CHAN_BIT] ? ST_IDLE : ST_PAIR_MODE;
      ST_PAIR_MODE: if (done) nxt_state = ST_RX_MODE;
      ST_RX_MODE:   if (done) nxt_state = ST_RX_CONFIG;
      ST_RX_CONFIG: if (done) nxt_state = ST_RATE;
      ST_RATE:      if (done) nxt_state = ST_CLEAR_ERR;
      ST_CLEAR_ERR: if (done) nxt_state = ST_START;
      ST_START:     if (done) nxt_state = ST_RUN;
      ST_RUN:
        // errors first, then data, then stop, then transmit work
        if (rx_err_ff)
          nxt_state = ST_READ_ERR;
        else if (rx_end_ff)
          nxt_state = ST_READ_DATA;
        else if (stop_ff)
          nxt_state = ST_STOP;
        else if (lin_ff)
          nxt_state = ST_WAKE;
        else if (tx_pend_ff)
          nxt_state = ST_DATA;
      ST_READ_DATA: if (done) nxt_state = ST_RUN;
      ST_READ_ERR:  if (done) nxt_state = ST_CLEAR_RUN;
      ST_CLEAR_RUN: if (done) nxt_state = ST_RUN;
      ST_STOP:      if (done) nxt_state = ST_CLK_OFF;
      ST_CLK_OFF:   if (done) nxt_state = ST_IDLE;
      ST_WAKE:      if (done) nxt_state = ST_WAKE_W;
      ST_WAKE_W:    if (lin_done_ff) nxt_state = ST_BREAK;
      ST_BREAK:     if (done) nxt_state = ST_BREAK_W;
      ST_BREAK_W:   if (lin_done_ff) nxt_state = ST_SYNC;
      ST_SYNC:      if (done) nxt_state = ST_SYNC_W;
      ST_SYNC_W:    if (lin_done_ff) nxt_state = ST_RUN;
      ST_DATA:      if (done) nxt_state = ST_DATA_W;
      ST_DATA_W:    if (lin_done_ff) nxt_state = ST_RUN;
    endcase
  end

  // =====================================================================
  // state, counter and access tracking
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      wait_ff  <= 3'h0;
      pend_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      wait_ff  <= (state_ff == ST_CLK_WAIT) ? wait_ff + 3'h1 : 3'h0;
      pend_ff  <= done ? 1'b0 : (pend_ff | acc);
    end
  end

  // =====================================================================
  // software settings, held while the channel runs
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prescaler_ff <= 16'h0000;
      mode_ff      <= 16'h0000;
      pair_ff      <= 16'h0000;
      comm_ff      <= 16'h0000;
      div_norm_ff  <= 7'h7F;
      div_wake_ff  <= 7'h7F;
    end
    else if (sw_we_i && state_ff == ST_IDLE)
    begin
      if (sw_addr_i == `SW_CFG_PRESCALER)
        prescaler_ff <= sw_wdata_i[15:0];
      if (sw_addr_i == `SW_CFG_MODE)
        mode_ff <= sw_wdata_i[15:0];
      if (sw_addr_i == `SW_CFG_PAIR)
        pair_ff <= sw_wdata_i[15:0];
      if (sw_addr_i == `SW_CFG_COMM)
        comm_ff <= sw_wdata_i[15:0];
      if (sw_addr_i == `SW_RATE)
      begin
        div_norm_ff <= sw_wdata_i[6:0];
        div_wake_ff <= sw_wdata_i[14:8];
      end
    end
  end

  // =====================================================================
  // request and event flags; a set wins over a clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      go_ff       <= 1'b0;
      stop_ff     <= 1'b0;
      lin_ff      <= 1'b0;
      rx_end_ff   <= 1'b0;
      rx_err_ff   <= 1'b0;
      lin_done_ff <= 1'b0;
      tx_pend_ff  <= 1'b0;
      tx_byte_ff  <= 8'h00;
      cfg_err_ff  <= 1'b0;
    end
    else
    begin
      go_ff   <= (wr_ctrl && sw_wdata_i[`CTRL_START]) ||
                 (go_ff && state_ff != ST_IDLE);
      stop_ff <= (wr_ctrl && sw_wdata_i[`CTRL_STOP]) ||
                 (stop_ff && state_ff != ST_STOP);
      lin_ff  <= (wr_ctrl && sw_wdata_i[`CTRL_LIN]) ||
                 (lin_ff && state_ff != ST_WAKE);
      rx_end_ff <= irq_rise[0] ||
                   (rx_end_ff && !(state_ff == ST_READ_DATA && done));
      rx_err_ff <= irq_rise[1] ||
                   (rx_err_ff && !(state_ff == ST_READ_ERR && done));
      lin_done_ff <= irq_rise[2] ||
                     (lin_done_ff && state_ff != ST_WAKE_W &&
                      state_ff != ST_BREAK_W && state_ff != ST_SYNC_W &&
                      state_ff != ST_DATA_W);
      if (sw_we_i && sw_addr_i == `SW_TX_BYTE)
      begin
        tx_byte_ff <= sw_wdata_i[7:0];
        tx_pend_ff <= 1'b1;
      end
      else if (state_ff == ST_DATA && done)
        tx_pend_ff <= 1'b0;
      if (state_ff == ST_IDLE && go_ff && div_bad)
        cfg_err_ff <= 1'b1;
      else if (state_ff == ST_CHECK_EN && done &&
               dev_rd[`DEV_RX_CHAN_BIT])
        cfg_err_ff <= 1'b1;
      else if (wr_ctrl && sw_wdata_i[`CTRL_CLR_ERR])
        cfg_err_ff <= 1'b0;
    end
  end

  // =====================================================================
  // received data and error record
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_byte_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      host_ovr_ff <= 1'b0;
      err_ff      <= 3'h0;
    end
    else
    begin
      if (state_ff == ST_READ_DATA && done)
      begin
        rx_byte_ff  <= dev_rd[7:0];
        rx_valid_ff <= 1'b1;
        if (rx_valid_ff && !rd_rx)
          host_ovr_ff <= 1'b1;
      end
      else if (rd_rx)
        rx_valid_ff <= 1'b0;
      if (state_ff == ST_READ_ERR && done)
        err_ff <= err_ff | dev_rd[2:0];
      else if (wr_ctrl && sw_wdata_i[`CTRL_CLR_ERR])
        err_ff <= 3'h0;
      // a byte lost in the cycle of the clear still shows
      if (wr_ctrl && sw_wdata_i[`CTRL_CLR_ERR] &&
          !(state_ff == ST_READ_DATA && done && rx_valid_ff && !rd_rx))
        host_ovr_ff <= 1'b0;
    end
  end

  // =====================================================================
  // software read data, one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sw_rdata_o <= 32'h0000_0000;
    else if (!sw_re_i)
      sw_rdata_o <= 32'h0000_0000;
    else if (sw_addr_i == `SW_RX_BYTE)
      sw_rdata_o <= {23'h000000, rx_valid_ff, rx_byte_ff};
    else if (sw_addr_i == `SW_STATUS)
      sw_rdata_o <= {20'h00000, state_ff, host_ovr_ff, cfg_err_ff,
                     err_ff, tx_pend_ff, (state_ff != ST_IDLE)};
    else if (sw_addr_i == `SW_RATE)
      sw_rdata_o <= {17'h00000, div_wake_ff, 1'b0, div_norm_ff};
    else
      sw_rdata_o <= 32'h0000_0000;
  end

endmodule

// ---- uart_lin_host_assertions.sv ----
// timing and value checks on the host controller ports
`include "uart_lin_map.svh"
`timescale 1ns/100ps
module uart_lin_host_checker
  import uart_lin_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        sw_re_i,
  input wire logic [31:0] sw_rdata_o,
  input dev_addr_t        dev_addr_o,
  input dev_word_t        dev_wdata_o,
  input wire logic        dev_we_o,
  input wire logic        dev_re_o
);
  // ======
  // helpers
  logic [2:0] gap_ff;   // clocks since the units were switched on
  logic [2:0] nxt_gap;  // saturating count
  wire        wr_on = dev_we_o && dev_addr_o == `DEV_PERIPH_EN
                      && dev_wdata_o == `DEV_UNITS_ON;
  wire        wr_x = dev_we_o && (dev_addr_o == `DEV_RX_DATA
                      || dev_addr_o == `DEV_TX_DATA);
  assign nxt_gap = wr_on ? 3'h1 : gap_ff + {2'h0, gap_ff != 3'h7};
  // count restarts at each switch-on
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      gap_ff <= 3'h0;
    else
      gap_ff <= nxt_gap;
  // ======
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_strobe_excl: assert property (!(dev_we_o && dev_re_o))
    else $error("device strobes high together");
  a_access_gap: assert property ((dev_we_o || dev_re_o)
    |=> !(dev_we_o || dev_re_o)) else $error("device accesses too close");
  a_prescaler_wait: assert property (dev_we_o &&
    dev_addr_o == `DEV_PRESCALER |-> gap_ff >= `PER_WAIT_CLKS)
    else $error("prescaler written too early");
  a_divider_min: assert property (wr_x
    |-> dev_wdata_o[15:9] >= `DIV_MIN) else $error("divider below two");
  a_stop_units_off: assert property (dev_we_o &&
    dev_addr_o == `DEV_STOP_TRIG |-> ##[1:8] (dev_we_o && dev_addr_o ==
    `DEV_PERIPH_EN && dev_wdata_o == `DEV_UNITS_OFF))
    else $error("units not switched off after stop");
  a_clear_all: assert property (dev_we_o &&
    dev_addr_o == `DEV_ERR_CLEAR |-> dev_wdata_o == `DEV_ERR_MASK)
    else $error("error clear value wrong");
  a_start_chan: assert property (dev_we_o &&
    dev_addr_o == `DEV_START_TRIG |-> dev_wdata_o == `DEV_CHAN_BITS)
    else $error("start trigger value wrong");
  a_rdata_idle: assert property (!$past(sw_re_i) |-> sw_rdata_o == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind uart_lin_host uart_lin_host_checker chk (.clk_i(clk_i),
  .rst_i(rst_i), .sw_re_i(sw_re_i), .sw_rdata_o(sw_rdata_o),
  .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o),
  .dev_we_o(dev_we_o), .dev_re_o(dev_re_o));

// ---- dev_model.sv ----
// behavioural serial unit seen through its register port
`include "uart_lin_map.svh"
`timescale 1ns/100ps
module dev_model
  import uart_lin_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  dev_addr_t addr_i,
  input  dev_word_t wdata_i,
  input  wire logic we_i,
  input  wire logic re_i,
  output dev_word_t rdata_o,
  output logic      rx_end_o,
  output logic      rx_err_o,
  output logic      lin_irq_o
);
  dev_word_t  regs [0:11];      // one word per even address
  logic [4:0] tx_ff;            // frame time left on the transmit pin
  wire  [3:0] idx = addr_i[4:1];
  // transfer end pulse near the end of each frame
  assign lin_irq_o = tx_ff != 5'h0 && tx_ff < 5'h5;
  initial
  begin
    rx_end_o = 1'b0;
    rx_err_o = 1'b0;
  end
  // ======
  // register file; unread data toggles so stale values never match
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      foreach (regs[i]) regs[i] <= 16'h0000;
      rdata_o <= 16'h0000;
      tx_ff <= 5'h00;
    end
    else
    begin
      rdata_o <= re_i ? regs[idx] : ~rdata_o;
      if (tx_ff != 5'h0)
        tx_ff <= tx_ff - 5'h1;
      if (we_i)
        regs[idx] <= wdata_i;
      if (we_i && addr_i == `DEV_START_TRIG)
        regs[10] <= regs[10] | wdata_i;
      if (we_i && addr_i == `DEV_STOP_TRIG)
        regs[10] <= regs[10] & ~wdata_i;
      if (we_i && addr_i == `DEV_ERR_CLEAR)
        regs[6] <= regs[6] & ~wdata_i;
      if (we_i && addr_i == `DEV_TX_DATA)
        tx_ff <= 5'h14;
    end
  // one received character, only once the odd channel runs
  task automatic deliver(input logic [7:0] b, input logic [2:0] e);
    @(posedge clk_i);
    if (regs[10][`DEV_RX_CHAN_BIT])
    begin
      regs[5][7:0] <= b;
      regs[6] <= regs[6] | {13'h0000, e};
      rx_err_o <= e != 3'h0;
      rx_end_o <= e == 3'h0;
      repeat (5) @(posedge clk_i);
    end
    rx_err_o <= 1'b0;
    rx_end_o <= 1'b0;
  endtask
endmodule

// ---- uart_lin_host_test.sv ----
// testbench for the host controller against the device model
`include "uart_lin_map.svh"
`timescale 1ns/100ps
module uart_lin_host_test;
  import uart_lin_pkg::*;
  localparam int norm_div = 8;   // normal divider under test
  localparam int brk_div = (((norm_div + 1) * 26 / 9) + 1) / 2 - 1;
  logic        clk_i, rst_i, sw_we_i, sw_re_i, rx_end, rx_err, lin_irq;
  logic [7:0]  sw_addr_i;
  logic [31:0] sw_wdata_i, sw_rdata_o, rd_v;
  dev_addr_t   dev_addr_o;
  dev_word_t   dev_wdata_o, dev_rdata_i;
  logic        dev_we_o, dev_re_o;
  int          failures, comparisons;
  logic [23:0] log_q [$];        // device writes in order
  uart_lin_host dut (.clk_i(clk_i), .rst_i(rst_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_we_i(sw_we_i), .sw_re_i(sw_re_i),
    .sw_rdata_o(sw_rdata_o), .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o), .dev_we_o(dev_we_o), .dev_re_o(dev_re_o),
    .dev_rdata_i(dev_rdata_i), .rx_end_irq_i(rx_end),
    .rx_err_irq_i(rx_err), .lin_tx_irq_i(lin_irq));
  dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .addr_i(dev_addr_o),
    .wdata_i(dev_wdata_o), .we_i(dev_we_o), .re_i(dev_re_o),
    .rdata_o(dev_rdata_i), .rx_end_o(rx_end), .rx_err_o(rx_err),
    .lin_irq_o(lin_irq));
  // ======
  // clock, monitor and tasks
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (dev_we_o === 1'b1)
      log_q.push_back({dev_addr_o, dev_wdata_o});
  task complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_we_i <= 1'b1;
    @(posedge clk_i);
    sw_we_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_re_i <= 1'b1;
    @(posedge clk_i);
    sw_re_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask
  // next device write must match, within a bounded wait
  task expect_wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    for (n = 0; n < 400 && log_q.size() == 0; n++) @(posedge clk_i);
    if (log_q.size() == 0)
    begin
      failures++;
      complete_run();
    end
    else
      check({8'h00, log_q.pop_front()}, {8'h00, a, d});
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  // ======
  // main sequence
  initial
  begin
    int n;
    rst_i = 1'b1;
    sw_we_i = 1'b0;
    sw_re_i = 1'b0;
    sw_addr_i = 8'h00;
    sw_wdata_i = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SW_STATUS, rd_v);
    check(rd_v, 32'h0);
    rd(8'h3C, rd_v);
    check(rd_v, 32'h0);
    wr(`SW_RATE, 32'h2001);
    wr(`SW_CTRL, 32'h1);
    repeat (4) @(posedge clk_i);
    rd(`SW_STATUS, rd_v);
    check(rd_v & 32'h21, 32'h20);
    check(log_q.size(), 32'h0);
    wr(`SW_RATE, 32'h2000 | norm_div);
    wr(`SW_CFG_PRESCALER, 32'h0011);
    wr(`SW_CFG_MODE, 32'h0022);
    wr(`SW_CFG_PAIR, 32'h0033);
    wr(`SW_CFG_COMM, 32'h0044);
    wr(`SW_CTRL, 32'h1);
    expect_wr(`DEV_PERIPH_EN, 16'h0003);
    expect_wr(`DEV_PRESCALER, 16'h0011);
    expect_wr(`DEV_PAIR_MODE, 16'h0033);
    expect_wr(`DEV_RX_MODE, 16'h0022);
    expect_wr(`DEV_RX_CONFIG, 16'h0044);
    expect_wr(`DEV_RX_DATA, 16'(norm_div << 9));
    expect_wr(`DEV_ERR_CLEAR, 16'h0007);
    expect_wr(`DEV_START_TRIG, 16'h000C);
    #1 check(dev.regs[10], 32'h000C);
    dev.deliver(8'h00, 3'h5);
    expect_wr(`DEV_ERR_CLEAR, 16'h0007);
    rd(`SW_STATUS, rd_v);
    check(rd_v & 32'h1C, 32'h14);
    dev.deliver(8'hA5, 3'h0);
    rd_v = 32'h0;
    for (n = 0; n < 60 && rd_v[8] !== 1'b1; n++) rd(`SW_RX_BYTE, rd_v);
    check(rd_v, 32'h1A5);
    rd(`SW_RX_BYTE, rd_v);
    check(rd_v & 32'h100, 32'h0);
    wr(`SW_CTRL, 32'h4);
    expect_wr(`DEV_TX_DATA, 16'h4000);
    expect_wr(`DEV_TX_DATA, 16'(brk_div << 9));
    expect_wr(`DEV_TX_DATA, 16'(norm_div << 9) | 16'h55);
    wr(`SW_TX_BYTE, 32'h3C);
    expect_wr(`DEV_TX_DATA, 16'(norm_div << 9) | 16'h3C);
    wr(`SW_CTRL, 32'h2);
    expect_wr(`DEV_STOP_TRIG, 16'h000C);
    expect_wr(`DEV_PERIPH_EN, 16'h0000);
    check(dev.regs[10], 32'h0);
    complete_run();
  end
endmodule
